// ---- core/sixteen_bit_timer_capture_compare.sv ----
// 16-bit timer with two capture/compare registers on a wishbone slave
module sixteen_bit_timer_capture_compare
  import timer_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trigger inputs and timer output
  input wire logic first_trigger_input,
  input wire logic second_trigger_input,
  output logic timer_output_pin,
  // match and capture events
  output logic first_match_irq,
  output logic second_match_irq
);
  function automatic logic [31:0] byte_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  logic [1:0] mode_r;
  logic ovf_r, ovf_hold_r;
  logic [2:0] cctrl_r;
  logic [5:0] octrl_r;
  logic [7:0] presc_r;
  logic [15:0] first_cc_r, second_cc_r, cnt_r, cnt_buf_r;
  logic [3:0] div_r;
  logic out_r, pin_r, ack_r, os_act_r;
  logic [31:0] dat_r;
  logic pend1_r, pend2_r, irq1_r, irq2_r;
  logic [15:0] cnt_nxt;
  logic out_nxt, ovf_nxt;

  edge_if e1();
  edge_if e2();

  edge_detect u_edge1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin(first_trigger_input),
    .e(e1.det)
  );

  edge_detect u_edge2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin(second_trigger_input),
    .e(e2.det)
  );

  // bus decode
  // taken only while ack is low, so one request per bus cycle
  wire acc = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = acc & wb_we_i;
  wire hit_mode = wb_adr_i == OFS_MODE;
  wire hit_cctrl = wb_adr_i == OFS_CCTRL;
  wire hit_octrl = wb_adr_i == OFS_OCTRL;
  wire hit_presc = wb_adr_i == OFS_PRESC;
  wire hit_count = wb_adr_i == OFS_COUNT;
  wire hit_first = wb_adr_i == OFS_FIRST_CC;
  wire hit_second = wb_adr_i == OFS_SECOND_CC;

  wire [31:0] mode_rd = {28'h0000000, mode_r, 1'b0, ovf_r};
  wire [31:0] cctrl_rd = {29'h00000000, cctrl_r};
  wire [31:0] octrl_rd = {26'h0000000, octrl_r};
  wire [31:0] presc_rd = {24'h000000, presc_r};
  wire [31:0] count_rd = {16'h0000, cnt_buf_r};
  wire [31:0] first_rd = {16'h0000, first_cc_r};
  wire [31:0] second_rd = {16'h0000, second_cc_r};

  // unmapped offsets fall through to zero
  wire [31:0] rd_mux = hit_mode ? mode_rd :
                       hit_cctrl ? cctrl_rd :
                       hit_octrl ? octrl_rd :
                       hit_presc ? presc_rd :
                       hit_count ? count_rd :
                       hit_first ? first_rd :
                       hit_second ? second_rd : 32'h00000000;

  wire [31:0] mode_wd = byte_merge(mode_rd, wb_dat_i, wb_sel_i);
  wire [31:0] cctrl_wd = byte_merge(cctrl_rd, wb_dat_i, wb_sel_i);
  wire [31:0] octrl_wd = byte_merge(octrl_rd, wb_dat_i, wb_sel_i);
  wire [31:0] presc_wd = byte_merge(presc_rd, wb_dat_i, wb_sel_i);
  wire [31:0] first_wd = byte_merge(first_rd, wb_dat_i, wb_sel_i);
  wire [31:0] second_wd = byte_merge(second_rd, wb_dat_i, wb_sel_i);

  wire wr_mode = wr & hit_mode;
  wire wr_octrl = wr & hit_octrl;

  wire run = mode_r != MODE_STOP;
  wire [1:0] psel = presc_r[PSEL_HI:PSEL_LO];
  wire ext_clk = psel == PSEL_EXT;

  // prescaled count clock as a one-cycle enable
  wire pre_tick = (psel == PSEL_MCLK) |
                  ((psel == PSEL_DIV4) & (div_r[1:0] == DIV4_LAST)) |
                  ((psel == PSEL_DIV16) & (div_r == DIV16_LAST));
  // count source is either the prescaler or the first input's edge
  wire tick = ext_clk ? e1.valid_edge : pre_tick;

  assign e1.sample_en = ext_clk ? 1'b1 : pre_tick;
  assign e2.sample_en = ext_clk ? 1'b1 : pre_tick;
  assign e1.run = run;
  assign e2.run = run;
  assign e1.edge_sel = presc_r[ES1_HI:ES1_LO];
  assign e2.edge_sel = presc_r[ES2_HI:ES2_LO];

  wire in1_cap_ok = ~ext_clk;
  wire first_cap = cctrl_r[FIRST_CAP_BIT];
  wire first_src = cctrl_r[FIRST_SRC_BIT];
  wire second_cap = cctrl_r[SECOND_CAP_BIT];

  wire cap2 = run & second_cap & e1.valid_edge & in1_cap_ok;
  wire cap1 = run & first_cap &
              (first_src ? (e1.rev_edge & in1_cap_ok) : e2.valid_edge);
  wire ev1 = run & first_cap & (first_src ? e2.valid_edge : cap1);
  wire ev2 = cap2;

  // compare matches happen on the count enable
  wire m1 = run & tick & ~first_cap & (cnt_r == first_cc_r);
  wire m2 = run & tick & ~second_cap & (cnt_r == second_cc_r);

  wire os_ok = octrl_r[OS_EN_BIT] &
               ((mode_r == MODE_FREE) | (mode_r == MODE_CLR_EDGE));
  wire sw_trig = wr_octrl & octrl_wd[OS_TRIG_BIT] & os_ok;
  wire edge_trig = os_ok & (mode_r == MODE_CLR_EDGE) & e1.valid_edge;
  wire os_gate = ~os_ok | os_act_r;
  wire tog1 = m1 & octrl_r[TOG1_BIT] & os_gate;
  wire tog2 = m2 & octrl_r[TOG2_BIT] & os_gate;

  wire edge_clr = (mode_r == MODE_CLR_EDGE) & e1.valid_edge;
  wire match_clr = (mode_r == MODE_CLR_MATCH) & tick &
                   (cnt_r == first_cc_r);
  // a software one-shot trigger restarts the count in free-run and clear-on-edge modes
  wire cnt_clr = edge_clr | match_clr | sw_trig;

  wire ovf_set = run & tick & (cnt_r == CNT_MAX) & ~edge_clr & ~sw_trig;
  wire ovf_clr = wr_mode & ~mode_wd[OVF_BIT] & ~ovf_hold_r;

  wire [1:0] lvl = {octrl_wd[LVS_BIT], octrl_wd[LVR_BIT]};
  wire preset_ok = wr_octrl & (mode_r == MODE_STOP);

  always_comb begin
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = CNT_ZERO;
    end else if (cnt_clr) begin
      cnt_nxt = CNT_ZERO;
    end else if (tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_comb begin
    out_nxt = out_r ^ tog1 ^ tog2;
    if (preset_ok) begin
      case (lvl)
        LVL_LOW: out_nxt = 1'b0;
        LVL_HIGH: out_nxt = 1'b1;
        default: out_nxt = out_r;
      endcase
    end
  end

  // set wins over a same-cycle clear
  assign ovf_nxt = ovf_set | (ovf_r & ~ovf_clr);

  // divider runs free, so the first prescaled tick may come early
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= CNT_ZERO;
      cnt_buf_r <= CNT_ZERO;
      div_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
      cnt_buf_r <= cnt_nxt;
      div_r <= div_r + 4'h1;
    end
  end

  // hold blocks a software clear until the next count tick
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_r <= 1'b0;
      ovf_hold_r <= 1'b0;
    end else begin
      ovf_r <= ovf_nxt;
      // hold until the counter moves past 0000
      ovf_hold_r <= ovf_set | (ovf_hold_r & ~(tick | ~run));
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_STOP;
      cctrl_r <= 3'h0;
      octrl_r <= 6'h00;
      presc_r <= 8'h00;
    end else begin
      if (wr_mode) mode_r <= mode_wd[MODE_HI:MODE_LO];
      if (wr & hit_cctrl) cctrl_r <= cctrl_wd[2:0];
      if (wr_octrl) begin
        octrl_r[OUT_EN_BIT] <= octrl_wd[OUT_EN_BIT];
        octrl_r[TOG1_BIT] <= octrl_wd[TOG1_BIT];
        octrl_r[TOG2_BIT] <= octrl_wd[TOG2_BIT];
        octrl_r[OS_EN_BIT] <= octrl_wd[OS_EN_BIT];
        if (mode_r == MODE_STOP) begin
          octrl_r[LVS_BIT] <= octrl_wd[LVS_BIT];
          octrl_r[LVR_BIT] <= octrl_wd[LVR_BIT];
        end
      end
      if (wr & hit_presc) presc_r <= presc_wd[7:0];
    end
  end

  // a read in the capture cycle sees the old value
  // capture beats bus write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      first_cc_r <= CNT_ZERO;
      second_cc_r <= CNT_ZERO;
    end else begin
      if (cap1) begin
        first_cc_r <= cnt_r;
      end else if (wr & hit_first) begin
        first_cc_r <= first_wd[15:0];
      end
      if (cap2) begin
        second_cc_r <= cnt_r;
      end else if (wr & hit_second) begin
        second_cc_r <= second_wd[15:0];
      end
    end
  end

  // captured events wait for the next tick before they signal
  // interrupt at next count
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend1_r <= 1'b0;
      pend2_r <= 1'b0;
      irq1_r <= 1'b0;
      irq2_r <= 1'b0;
    end else begin
      pend1_r <= ev1 | (pend1_r & ~tick & run);
      pend2_r <= ev2 | (pend2_r & ~tick & run);
      irq1_r <= m1 | (pend1_r & tick);
      irq2_r <= m2 | (pend2_r & tick);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      pin_r <= octrl_r[OUT_EN_BIT] & out_nxt;
    end
  end

  // window opens on a trigger and closes at the second match
  // one-shot active window
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      os_act_r <= 1'b0;
    end else if (!os_ok) begin
      os_act_r <= 1'b0;
    end else if (sw_trig | edge_trig) begin
      os_act_r <= 1'b1;
    end else if (m2) begin
      os_act_r <= 1'b0;
    end
  end

  // one-cycle ack; unmapped reads return zero, writes are dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= acc;
      if (acc & ~wb_we_i) dat_r <= rd_mux;
    end
  end

  // every output leaves the block from a flip-flop
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign timer_output_pin = pin_r;
  assign first_match_irq = irq1_r;
  assign second_match_irq = irq2_r;
endmodule

// ---- common/timer_pkg.sv ----
// constants for the 16-bit capture/compare timer and its bus registers
package timer_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CCTRL = 8'h04;
  localparam logic [7:0] OFS_OCTRL = 8'h08;
  localparam logic [7:0] OFS_PRESC = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_FIRST_CC = 8'h14;
  localparam logic [7:0] OFS_SECOND_CC = 8'h18;
  // mode_control_reg fields
  localparam int OVF_BIT = 0;
  localparam int MODE_LO = 2;
  localparam int MODE_HI = 3;
  // capture_compare_ctrl_reg fields
  localparam int FIRST_CAP_BIT = 0;
  localparam int FIRST_SRC_BIT = 1;
  localparam int SECOND_CAP_BIT = 2;
  // output_control_reg fields
  localparam int OUT_EN_BIT = 0;
  localparam int TOG1_BIT = 1;
  localparam int LVR_BIT = 2;
  localparam int LVS_BIT = 3;
  localparam int TOG2_BIT = 4;
  localparam int OS_EN_BIT = 5;
  localparam int OS_TRIG_BIT = 6;
  // prescaler_mode_reg fields
  localparam int PSEL_LO = 0;
  localparam int PSEL_HI = 1;
  localparam int ES1_LO = 4;
  localparam int ES1_HI = 5;
  localparam int ES2_LO = 6;
  localparam int ES2_HI = 7;
  // operating modes
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
  localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
  // output level preset codes {set, reset}
  localparam logic [1:0] LVL_KEEP = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // count clock selection
  localparam logic [1:0] PSEL_MCLK = 2'h0;
  localparam logic [1:0] PSEL_DIV4 = 2'h1;
  localparam logic [1:0] PSEL_DIV16 = 2'h2;
  localparam logic [1:0] PSEL_EXT = 2'h3;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [3:0] DIV16_LAST = 4'hF;
  // edge selection codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // counter limits
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage

// ---- common/edge_if.sv ----
// carrier between the timer core and one input edge detector
interface edge_if;
  logic sample_en;
  logic run;
  logic [1:0] edge_sel;
  logic valid_edge;
  logic rev_edge;
  modport owner(output sample_en, output run, output edge_sel,
    input valid_edge, input rev_edge);
  modport det(input sample_en, input run, input edge_sel,
    output valid_edge, output rev_edge);
endinterface

// ---- core/edge_detect.sv ----
// synchroniser, two-sample noise filter and edge selector for one input
module edge_detect
  import timer_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // pin and core side
  input wire logic pin,
  edge_if.det e
);
  logic s1_r, s2_r, samp_r, filt_r, seen_r, valid_r, rev_r;

  // filter keeps tracking once the timer has run at least once
  wire track = e.run | seen_r;
  wire agree = e.sample_en & track & (samp_r == s2_r);
  wire change = agree & (s2_r != filt_r);
  wire rise = change & s2_r;
  wire fall = change & ~s2_r;
  wire sel_hit = (e.edge_sel == EDGE_RISE) ? rise :
                 (e.edge_sel == EDGE_FALL) ? fall :
                 (e.edge_sel == EDGE_BOTH) ? (rise | fall) : 1'b0;
  wire sel_rev = (e.edge_sel == EDGE_RISE) ? fall :
                 (e.edge_sel == EDGE_FALL) ? rise : 1'b0;

  assign e.valid_edge = valid_r;
  assign e.rev_edge = rev_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      samp_r <= 1'b0;
      filt_r <= 1'b0;
    end else if (e.sample_en && track) begin
      samp_r <= s2_r;
      if (samp_r == s2_r) filt_r <= s2_r;
    end
  end

  // first start edge
  // filt_r starts low, so a high pin at first start reads as a rise
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seen_r <= 1'b0;
      valid_r <= 1'b0;
      rev_r <= 1'b0;
    end else begin
      seen_r <= seen_r | e.run;
      valid_r <= e.run & sel_hit;
      rev_r <= e.run & sel_rev;
    end
  end
endmodule

// ---- dv/timer_asserts.sv ----
// bus handshake, reset and output pin checks on the timer top ports
module timer_asserts
  import timer_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and events
  input wire logic first_trigger_input,
  input wire logic second_trigger_input,
  input wire logic timer_output_pin,
  input wire logic first_match_irq,
  input wire logic second_match_irq
);
  logic [1:0] mode_r;
  wire logic wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  wire logic oc_en = wr_ack && wb_adr_i == OFS_OCTRL
    && mode_r == MODE_STOP && wb_dat_i[OUT_EN_BIT];
  wire logic [1:0] lvl = {wb_dat_i[LVS_BIT], wb_dat_i[LVR_BIT]};
  wire logic cause = wb_ack_o || first_match_irq || second_match_irq;
  // mode mirror, so preset checks only fire while stopped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_STOP;
    end else if (wr_ack && wb_adr_i == OFS_MODE) begin
      mode_r <= wb_dat_i[MODE_HI:MODE_LO];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_rdata_holds: assert property ($changed(wb_dat_o) |-> rd_ack)
    else $error("read data changed outside a read");
  a_reset_quiet: assert property ($rose(rst_b) |-> !(wb_ack_o
    || timer_output_pin || first_match_irq || second_match_irq))
    else $error("output active at reset release");
  a_pin_has_cause: assert property (
    $changed(timer_output_pin) |-> cause || $past(cause)
    || $past(cause, 2))
    else $error("output pin moved without cause");
  a_preset_high: assert property (
    oc_en && lvl == LVL_HIGH |=> ##[0:1] timer_output_pin)
    else $error("preset high not driven");
  a_preset_low: assert property (
    oc_en && lvl == LVL_LOW |=> ##[0:1] !timer_output_pin)
    else $error("preset low not driven");
  a_keep_high: assert property (
    oc_en && lvl == LVL_KEEP && timer_output_pin |=> timer_output_pin[*2])
    else $error("output left high level");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i > OFS_SECOND_CC
    && wb_adr_i[1:0] == 2'h0 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind sixteen_bit_timer_capture_compare timer_asserts timer_asserts_i (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .first_trigger_input(first_trigger_input),
  .second_trigger_input(second_trigger_input),
  .timer_output_pin(timer_output_pin), .first_match_irq(first_match_irq),
  .second_match_irq(second_match_irq)
);

// ---- dv/trig_model.sv ----
// far-side trigger source for the two capture inputs, idle low
module trig_model
(
  // clock
  input wire logic mclk,
  // trigger pins
  output logic first_trigger_input,
  output logic second_trigger_input
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    first_trigger_input = 1'b0;
    second_trigger_input = 1'b0;
  end
  // width in mclk cycles; callers pass 3 for real edges and 1 once for a pulse the filter drops
  task automatic pulse(input logic which, input int width);
    @(posedge mclk);
    if (which) second_trigger_input <= 1'b1;
    else first_trigger_input <= 1'b1;
    repeat (width) @(posedge mclk);
    first_trigger_input <= 1'b0;
    second_trigger_input <= 1'b0;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the 16-bit capture/compare timer
module tb_top
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 90000;
  logic mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, c0;
  logic first_trigger_input, second_trigger_input, timer_output_pin;
  logic first_match_irq, second_match_irq, hit;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  sixteen_bit_timer_capture_compare sixteen_bit_timer_capture_compare_i (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_trigger_input(first_trigger_input),
    .second_trigger_input(second_trigger_input),
    .timer_output_pin(timer_output_pin), .first_match_irq(first_match_irq),
    .second_match_irq(second_match_irq));
  trig_model trig_model_i (.mclk(mclk),
    .first_trigger_input(first_trigger_input),
    .second_trigger_input(second_trigger_input));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; the bound only guards against a missing ack
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    check_eq({31'h0, wb_ack_o}, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check_eq(q, exp);
  endtask
  task automatic pin_chk(input logic exp);
    repeat (2) @(posedge mclk);
    check_eq({31'h0, timer_output_pin}, {31'h0, exp});
  endtask
  task automatic wait_irq(input logic which, input int bound);
    hit = 1'b0;
    for (int i = 0; i < bound && !hit; i++) begin
      @(posedge mclk);
      if ((which ? second_match_irq : first_match_irq) === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic t_reset();
    for (logic [7:0] a = 8'h0; a <= 8'h1C; a += 8'h4) rd_chk(a, 32'h0);
    wb(1'b1, OFS_COUNT, 32'h1234);
    rd_chk(OFS_COUNT, 32'h0);
    rd_chk(8'hFC, 32'h0);
    pin_chk(1'b0);
  endtask
  task automatic t_count();
    wb(1'b1, OFS_MODE, 32'h4);
    wb(1'b0, OFS_COUNT, 32'h0);
    c0 = q;
    wb(1'b0, OFS_COUNT, 32'h0);
    check_eq(q - c0, 32'h3);
    check_eq({31'h0, c0 !== 32'h0}, 32'h1);
    wb(1'b1, OFS_MODE, 32'h0);
  endtask
  task automatic t_preset();
    wb(1'b1, OFS_OCTRL, 32'h9);
    pin_chk(1'b1);
    wb(1'b1, OFS_OCTRL, 32'h1);
    pin_chk(1'b1);
    wb(1'b1, OFS_OCTRL, 32'h5);
    pin_chk(1'b0);
    wb(1'b1, OFS_FIRST_CC, 32'h20);
    wb(1'b1, OFS_OCTRL, 32'hB);
    wb(1'b1, OFS_MODE, 32'h4);
    pin_chk(1'b1);
    wait_irq(1'b0, 60);
    check_eq({31'h0, hit}, 32'h1);
    pin_chk(1'b0);
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_OCTRL, 32'h0);
  endtask
  task automatic t_capture();
    wb(1'b1, OFS_PRESC, 32'h50);
    wb(1'b1, OFS_CCTRL, 32'h5);
    wb(1'b1, OFS_OCTRL, 32'h0);
    wb(1'b1, OFS_MODE, 32'h4);
    trig_model_i.pulse(1'b0, 1);
    wait_irq(1'b1, 12);
    check_eq({31'h0, hit}, 32'h0);
    trig_model_i.pulse(1'b0, 3);
    wait_irq(1'b1, 12);
    check_eq({31'h0, hit}, 32'h1);
    wb(1'b0, OFS_SECOND_CC, 32'h0);
    c0 = q;
    check_eq({31'h0, c0 !== 32'h0}, 32'h1);
    rd_chk(OFS_FIRST_CC, 32'h20);
    trig_model_i.pulse(1'b1, 3);
    wait_irq(1'b0, 12);
    check_eq({31'h0, hit}, 32'h1);
    wb(1'b0, OFS_FIRST_CC, 32'h0);
    check_eq({31'h0, q > c0}, 32'h1);
    c0 = q;
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_CCTRL, 32'h3);
    wb(1'b1, OFS_MODE, 32'h4);
    trig_model_i.pulse(1'b0, 3);
    wait_irq(1'b0, 20);
    check_eq({31'h0, hit}, 32'h0);
    wb(1'b0, OFS_FIRST_CC, 32'h0);
    check_eq({31'h0, q !== c0}, 32'h1);
    c0 = q;
    trig_model_i.pulse(1'b1, 3);
    wait_irq(1'b0, 20);
    check_eq({31'h0, hit}, 32'h1);
    rd_chk(OFS_FIRST_CC, c0);
    wb(1'b1, OFS_MODE, 32'h0);
  endtask
  task automatic t_overflow();
    wb(1'b1, OFS_CCTRL, 32'h0);
    wb(1'b1, OFS_PRESC, 32'h0);
    wb(1'b1, OFS_FIRST_CC, 32'hFFFF);
    wb(1'b1, OFS_SECOND_CC, 32'hFFF0);
    wb(1'b1, OFS_MODE, 32'hC);
    wait_irq(1'b1, 70000);
    check_eq({31'h0, hit}, 32'h1);
    // slow count so the clear lands before 0001
    wb(1'b1, OFS_PRESC, 32'h2);
    wait_irq(1'b0, 400);
    check_eq({31'h0, hit}, 32'h1);
    wb(1'b1, OFS_MODE, 32'hC);
    rd_chk(OFS_MODE, 32'hD);
    repeat (20) @(posedge mclk);
    wb(1'b1, OFS_MODE, 32'hC);
    rd_chk(OFS_MODE, 32'hC);
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_PRESC, 32'h0);
  endtask
  task automatic t_pulses();
    wb(1'b1, OFS_FIRST_CC, 32'h10);
    wb(1'b1, OFS_SECOND_CC, 32'h20);
    wb(1'b1, OFS_OCTRL, 32'h33);
    wb(1'b1, OFS_MODE, 32'h4);
    wb(1'b1, OFS_OCTRL, 32'h73);
    wait_irq(1'b0, 40);
    pin_chk(1'b1);
    wait_irq(1'b1, 40);
    check_eq({31'h0, hit}, 32'h1);
    pin_chk(1'b0);
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_FIRST_CC, 32'h40);
    wb(1'b1, OFS_SECOND_CC, 32'h10);
    wb(1'b1, OFS_OCTRL, 32'h13);
    wb(1'b1, OFS_MODE, 32'hC);
    wait_irq(1'b1, 200);
    wb(1'b1, OFS_OCTRL, 32'h3);
    wb(1'b1, OFS_SECOND_CC, 32'h8);
    @(posedge mclk);
    wb(1'b1, OFS_OCTRL, 32'h13);
    wait_irq(1'b1, 200);
    check_eq({31'h0, hit}, 32'h1);
    wb(1'b0, OFS_COUNT, 32'h0);
    check_eq({31'h0, q < 32'h10}, 32'h1);
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_OCTRL, 32'h0);
  endtask
  initial begin
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_count();
    t_preset();
    t_capture();
    t_overflow();
    t_pulses();
    complete_run();
  end
endmodule
